// file: src/sfr_bank.sv
// Special register bank with enable and flag bytes, APB slave and interrupt requests
`timescale 1ns/100ps

// Summary of operation
// (R1) Registers sit in lowest sixteen word locations
// (R2) Unassigned bits and bytes one, three absent
// (R3) All implemented bits readable and writable
// (R4) Power-up clear: enables, pin flag zero; osc one
// (R5) Power-on only sets power flag, clears reset/watchdog
// (R6) Watchdog enable inert in watchdog reset mode
// (R7) Interval mode: enable gates watchdog flag
// (R8) Bit one enables and flags oscillator fault
// (R9) Bit five flash violation, bit four pin
// (R10) Reset-mode pin event sets external reset flag
// (R11) Event-mode pin event sets pin flag
// (R12) Shared vector ignores global enable
// (R13) Empty bits read zero, writes ignored
// (R14) Request high while flag and enable both set
module sfr_bank
   import sfr_pkg::*;
(
   input wire logic clock_in, // System clock, 100 MHz
   input wire logic rst_in, // Synchronous power-up clear, active high
   input wire logic power_on_in, // Power-on reset, synchronous, active high
   input wire logic psel_in, // APB select
   input wire logic penable_in, // APB enable
   input wire logic pwrite_in, // APB direction, high for write
   input wire logic [31:0] paddr_in, // APB byte address
   input wire logic [31:0] pwdata_in, // APB write data
   output logic [31:0] prdata_out, // APB read data
   output logic pready_out, // APB ready
   output logic pslverr_out, // APB error for unmapped address
   input wire logic wdt_interval_mode_in, // Watchdog in interval timer mode
   input wire logic wdt_event_in, // Watchdog overflow pulse
   input wire logic osc_fault_in, // Oscillator fault pin level
   input wire logic pin_reset_mode_in, // Shared pin configured for reset
   input wire logic pin_event_in, // Shared pin event pulse, from pin
   input wire logic flash_violation_in, // Flash access violation pulse
   output logic wdt_irq_out, // Watchdog interval request
   output logic shared_irq_out, // High-priority shared vector request
   output logic irq_out // Summary interrupt from status/mask
);

   logic [7:0] irq_enable_one;
   logic [7:0] irq_flag_one;
   logic [3:0] int_status;
   logic [3:0] int_mask;
   logic osc_meta, osc_sync;
   logic pin_meta, pin_sync, pin_sync_d;
   logic pin_edge;
   logic wr_en, rd_en;
   logic [3:0] idx;
   logic idx_ok;
   logic [7:0] next_flag;
   logic wdt_req, shared_req;
   logic [3:0] events;

   // Decode word index inside the sixteen word locations
   function automatic logic [3:0] word_index(input logic [31:0] a);
      word_index = a[5:2];
   endfunction : word_index

   // Register hit on one word index, shared by write ports and checks
   function automatic logic reg_hit(input logic ok, input logic [3:0] at, input logic [3:0] target);
      reg_hit = ok && (at == target);
   endfunction : reg_hit

   assign idx = word_index(paddr_in);
   assign idx_ok = (paddr_in[31:6] == 26'h0) && (paddr_in[1:0] == 2'h0); // R1
   assign wr_en = psel_in && penable_in && pwrite_in;
   assign rd_en = psel_in && penable_in && !pwrite_in;

   // Two-stage synchronisers for pin inputs
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_sync_d <= 1'b0;
      end else begin
         osc_meta <= osc_fault_in;
         osc_sync <= osc_meta;
         pin_meta <= pin_event_in;
         pin_sync <= pin_meta;
         pin_sync_d <= pin_sync;
      end
   end

   // Rising edge of the synchronised pin event
   assign pin_edge = pin_sync && !pin_sync_d;

   // Enable byte; absent bits are never stored
   always_ff @(posedge clock_in) begin
      if (rst_in || power_on_in) begin
         irq_enable_one <= SFR_ENABLE_RESET; // R4
      end else if (wr_en && reg_hit(idx_ok, idx, SFR_IDX_ENABLE_ONE)) begin
         irq_enable_one <= pwdata_in[7:0] & SFR_ENABLE_MASK; // R3 R2 R13
      end
   end

   // Flag byte next value: software write first, hardware sets win
   always_comb begin
      next_flag = irq_flag_one;
      if (wr_en && reg_hit(idx_ok, idx, SFR_IDX_FLAG_ONE)) begin
         next_flag = pwdata_in[7:0] & SFR_FLAG_MASK; // R3 R13
      end
      if (wdt_event_in) begin
         next_flag[SFR_BIT_WDT_FLAG] = 1'b1;
      end
      if (osc_sync) begin
         next_flag[SFR_BIT_OSC_FLAG] = 1'b1; // R8
      end
      if (pin_edge && pin_reset_mode_in) begin
         next_flag[SFR_BIT_RST_FLAG] = 1'b1; // R10
      end
      if (pin_edge && !pin_reset_mode_in) begin
         next_flag[SFR_BIT_PIN_FLAG] = 1'b1; // R11
      end
   end

   // Flag byte: power-on and power-up clear touch different bits
   always_ff @(posedge clock_in) begin
      if (power_on_in) begin
         // Power-on also performs a clear: osc and power-on flags one, rest zero
         irq_flag_one <= SFR_FLAG_POR_RESET; // R4 R5
      end else if (rst_in) begin
         // Watchdog, power-on and reset flags survive a clear
         irq_flag_one[SFR_BIT_PIN_FLAG] <= 1'b0; // R4
         irq_flag_one[SFR_BIT_OSC_FLAG] <= 1'b1; // R4
      end else begin
         irq_flag_one <= next_flag;
      end
   end

   // Request gating; global enable plays no part here
   assign wdt_req = wdt_interval_mode_in && irq_enable_one[SFR_BIT_WDT_IE]
      && irq_flag_one[SFR_BIT_WDT_FLAG]; // R6 R7 R14
   assign shared_req = (irq_enable_one[SFR_BIT_OSC_IE] && irq_flag_one[SFR_BIT_OSC_FLAG])
      || (irq_enable_one[SFR_BIT_PIN_IE] && irq_flag_one[SFR_BIT_PIN_FLAG])
      || (irq_enable_one[SFR_BIT_FLASH_IE] && flash_violation_in); // R12 R9 R14

   // Registered request outputs
   always_ff @(posedge clock_in) begin
      if (rst_in || power_on_in) begin
         wdt_irq_out <= 1'b0;
         shared_irq_out <= 1'b0;
      end else begin
         wdt_irq_out <= wdt_req; // R14
         shared_irq_out <= shared_req; // R12
      end
   end

   // Sticky events for the summary interrupt
   assign events = {flash_violation_in, pin_edge, osc_sync, wdt_event_in};

   // Status: write one clears, a new event wins over the clear
   always_ff @(posedge clock_in) begin
      if (rst_in || power_on_in) begin
         int_status <= SFR_STATUS_RESET;
      end else if (wr_en && reg_hit(idx_ok, idx, SFR_IDX_INT_STATUS)) begin
         int_status <= (int_status & ~pwdata_in[3:0]) | events;
      end else begin
         int_status <= int_status | events;
      end
   end

   // Mask register
   always_ff @(posedge clock_in) begin
      if (rst_in || power_on_in) begin
         int_mask <= SFR_MASK_RESET;
      end else if (wr_en && reg_hit(idx_ok, idx, SFR_IDX_INT_MASK)) begin
         int_mask <= pwdata_in[3:0] & SFR_STATUS_MASK;
      end
   end

   // Level interrupt, one cycle after status changes
   always_ff @(posedge clock_in) begin
      if (rst_in || power_on_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(int_status & int_mask);
      end
   end

   // APB answer: no wait states, ready registered in setup cycle
   always_ff @(posedge clock_in) begin
      if (rst_in || power_on_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= SFR_RDATA_RESET;
      end else begin
         pready_out <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && !idx_ok;
         prdata_out <= SFR_RDATA_RESET;
         if (psel_in && !penable_in && !pwrite_in && idx_ok) begin
            case (idx)
               SFR_IDX_ENABLE_ONE: prdata_out <= {24'h0, irq_enable_one};
               SFR_IDX_FLAG_ONE: prdata_out <= {24'h0, irq_flag_one};
               SFR_IDX_INT_STATUS: prdata_out <= {28'h0, int_status};
               SFR_IDX_INT_MASK: prdata_out <= {28'h0, int_mask};
               default: prdata_out <= SFR_RDATA_RESET; // R2 R13
            endcase
         end
      end
   end

   // Assertions
   property p_enable_clean;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      (irq_enable_one & ~SFR_ENABLE_MASK) == 8'h00;
   endproperty
   a_enable_clean: assert property (p_enable_clean) else $error("enable bit outside mask set"); // R2

   property p_flag_clean;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      (irq_flag_one & ~SFR_FLAG_MASK) == 8'h00;
   endproperty
   a_flag_clean: assert property (p_flag_clean) else $error("flag bit outside mask set"); // R13

   property p_puc_values;
      @(posedge clock_in) rst_in && !power_on_in |=> irq_enable_one == 8'h00
         && irq_flag_one[SFR_BIT_OSC_FLAG] && !irq_flag_one[SFR_BIT_PIN_FLAG];
   endproperty
   a_puc_values: assert property (p_puc_values) else $error("power-up clear values wrong"); // R4

   property p_puc_keeps;
      @(posedge clock_in) rst_in && !power_on_in |=>
         irq_flag_one[SFR_BIT_RST_FLAG] == $past(irq_flag_one[SFR_BIT_RST_FLAG]);
   endproperty
   a_puc_keeps: assert property (p_puc_keeps) else $error("reset flag lost on clear"); // R5

   property p_por_flag;
      @(posedge clock_in) power_on_in |=> irq_flag_one[SFR_BIT_POR_FLAG] && !irq_flag_one[SFR_BIT_WDT_FLAG];
   endproperty
   a_por_flag: assert property (p_por_flag) else $error("power-on flag values wrong"); // R5

   property p_wdt_gate;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      !wdt_interval_mode_in |=> !wdt_irq_out;
   endproperty
   a_wdt_gate: assert property (p_wdt_gate) else $error("watchdog request in reset mode"); // R6

   property p_wdt_req;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      wdt_req |=> wdt_irq_out;
   endproperty
   a_wdt_req: assert property (p_wdt_req) else $error("interval request missing"); // R7

   property p_osc_set;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      osc_fault_in ##2 osc_fault_in |=> irq_flag_one[SFR_BIT_OSC_FLAG];
   endproperty
   a_osc_set: assert property (p_osc_set) else $error("oscillator fault flag not set"); // R8

   property p_pin_split;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      pin_edge && !pin_reset_mode_in |=> irq_flag_one[SFR_BIT_PIN_FLAG];
   endproperty
   a_pin_split: assert property (p_pin_split) else $error("pin event flag not set"); // R11

   property p_rst_pin;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      pin_edge && pin_reset_mode_in |=> irq_flag_one[SFR_BIT_RST_FLAG];
   endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("external reset flag not set"); // R10

   property p_shared;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      shared_req |=> shared_irq_out;
   endproperty
   a_shared: assert property (p_shared) else $error("shared request missing"); // R12

   property p_ready;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      psel_in && !penable_in |=> pready_out;
   endproperty
   a_ready: assert property (p_ready) else $error("apb ready late"); // R1

   // Register bus answers
   property p_slverr;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      psel_in && !penable_in && !idx_ok |=> pslverr_out;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access not refused"); // R1

   property p_empty_read;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      psel_in && !penable_in && !pwrite_in
         && (reg_hit(idx_ok, idx, SFR_IDX_ENABLE_TWO) || reg_hit(idx_ok, idx, SFR_IDX_FLAG_TWO))
         |=> prdata_out == SFR_RDATA_RESET;
   endproperty
   a_empty_read: assert property (p_empty_read) else $error("empty byte reads nonzero"); // R2

   // Software writes land, hardware sets excepted
   property p_enable_write;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      wr_en && reg_hit(idx_ok, idx, SFR_IDX_ENABLE_ONE)
         |=> irq_enable_one == ($past(pwdata_in[7:0]) & SFR_ENABLE_MASK);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable write lost"); // R3

   property p_flag_write;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      wr_en && reg_hit(idx_ok, idx, SFR_IDX_FLAG_ONE) && !wdt_event_in && !osc_sync && !pin_edge
         |=> irq_flag_one == ($past(pwdata_in[7:0]) & SFR_FLAG_MASK);
   endproperty
   a_flag_write: assert property (p_flag_write) else $error("flag write lost"); // R3

   // Flags hold until software or reset clears them
   property p_flag_sticky;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      irq_flag_one[SFR_BIT_PIN_FLAG] && !(wr_en && reg_hit(idx_ok, idx, SFR_IDX_FLAG_ONE))
         |=> irq_flag_one[SFR_BIT_PIN_FLAG];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("pin flag dropped by itself"); // R14

   property p_por_only;
      @(posedge clock_in) !power_on_in && !irq_flag_one[SFR_BIT_POR_FLAG]
         && !(wr_en && reg_hit(idx_ok, idx, SFR_IDX_FLAG_ONE)) |=> !irq_flag_one[SFR_BIT_POR_FLAG];
   endproperty
   a_por_only: assert property (p_por_only) else $error("power-on flag set without power-on"); // R5

   // Request outputs follow their gates
   property p_flash_req;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      irq_enable_one[SFR_BIT_FLASH_IE] && flash_violation_in |=> shared_irq_out;
   endproperty
   a_flash_req: assert property (p_flash_req) else $error("flash violation request missing"); // R9

   property p_shared_off;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      !shared_req |=> !shared_irq_out;
   endproperty
   a_shared_off: assert property (p_shared_off) else $error("shared request without gate"); // R12

   property p_summary;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      |(int_status & int_mask) |=> irq_out;
   endproperty
   a_summary: assert property (p_summary) else $error("summary interrupt missing"); // R14

   property p_status_set;
      @(posedge clock_in) disable iff (rst_in || power_on_in)
      |events |=> (int_status & $past(events)) == $past(events);
   endproperty
   a_status_set: assert property (p_status_set) else $error("status event lost"); // R14

   c_write_enable: cover property (@(posedge clock_in) wr_en && idx == SFR_IDX_ENABLE_ONE);
   c_wdt_irq: cover property (@(posedge clock_in) wdt_irq_out);
   c_shared_irq: cover property (@(posedge clock_in) shared_irq_out);
   c_summary_irq: cover property (@(posedge clock_in) irq_out);
   c_pin_event: cover property (@(posedge clock_in) pin_edge && !pin_reset_mode_in);

endmodule : sfr_bank

// file: src/sfr_pkg.sv
// Package with register map, bit positions and reset values of the special register bank
package sfr_pkg;
   // Printed offsets are indices, byte address is four times the index
   localparam logic [3:0] SFR_IDX_ENABLE_ONE = 4'h0;
   localparam logic [3:0] SFR_IDX_ENABLE_TWO = 4'h1;
   localparam logic [3:0] SFR_IDX_FLAG_ONE = 4'h2;
   localparam logic [3:0] SFR_IDX_FLAG_TWO = 4'h3;
   localparam logic [3:0] SFR_IDX_INT_STATUS = 4'h4;
   localparam logic [3:0] SFR_IDX_INT_MASK = 4'h5;
   localparam logic [3:0] SFR_IDX_LAST = 4'hf;
   // Enable register bit positions
   localparam int SFR_BIT_WDT_IE = 0;
   localparam int SFR_BIT_OSC_IE = 1;
   localparam int SFR_BIT_PIN_IE = 4;
   localparam int SFR_BIT_FLASH_IE = 5;
   // Flag register bit positions
   localparam int SFR_BIT_WDT_FLAG = 0;
   localparam int SFR_BIT_OSC_FLAG = 1;
   localparam int SFR_BIT_POR_FLAG = 2;
   localparam int SFR_BIT_RST_FLAG = 3;
   localparam int SFR_BIT_PIN_FLAG = 4;
   // Implemented bit masks
   localparam logic [7:0] SFR_ENABLE_MASK = 8'h33;
   localparam logic [7:0] SFR_FLAG_MASK = 8'h1f;
   // Status bits: 0 wdt, 1 osc, 2 pin, 3 flash
   localparam logic [3:0] SFR_STATUS_MASK = 4'hf;
   localparam logic [3:0] SFR_STATUS_RESET = 4'h0;
   localparam logic [3:0] SFR_MASK_RESET = 4'h0;
   // Values after power-up clear / power-on
   localparam logic [7:0] SFR_ENABLE_RESET = 8'h00;
   localparam logic [7:0] SFR_FLAG_POR_RESET = 8'h06;
   localparam logic [31:0] SFR_RDATA_RESET = 32'h0000_0000;
endpackage : sfr_pkg

// file: test/sfr_core_model.sv
// Processor core model issuing APB transfers to the register bank
`timescale 1ns/100ps
module sfr_core_model (
   input wire logic clock_in, // System clock
   output logic psel_out, // APB select
   output logic penable_out, // APB enable
   output logic pwrite_out, // APB direction
   output logic [31:0] paddr_out, // APB byte address
   output logic [31:0] pwdata_out, // APB write data
   input wire logic [31:0] prdata_in, // APB read data
   input wire logic pready_in, // APB ready
   input wire logic pslverr_in // APB error
);
   // Idle bus at time zero
   initial begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 32'h0000_0000;
      pwdata_out = 32'h0000_0000;
   end

   // One transfer, held until ready is seen at a rising edge
   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
      @(posedge clock_in);
      psel_out <= 1'b1;
      penable_out <= 1'b0;
      pwrite_out <= wr;
      paddr_out <= addr;
      pwdata_out <= wdata;
      @(posedge clock_in);
      penable_out <= 1'b1;
      // No cycle count assumed; only the bench timeout ends a hang
      do begin
         @(posedge clock_in);
      end while (pready_in !== 1'b1);
      rdata = prdata_in;
      err = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      // Released data no longer shows the last value
      pwdata_out <= ~wdata;
      paddr_out <= ~addr;
   endtask : xfer
endmodule : sfr_core_model

// file: test/tb_special_function_regs.sv
// Self-checking testbench of the special register bank
`timescale 1ns/100ps
module tb_special_function_regs;
   import sfr_pkg::*;
   logic clock_in, rst_in, power_on_in, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic wmode, wev, osc, pmode, pev, flash, wirq, sirq, irq, err;
   int num_errors = 0;
   int cmp_count = 0;
   int cycles = 0;

   sfr_core_model u_core (.clock_in(clock_in), .psel_out(psel), .penable_out(penable),
      .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata),
      .pready_in(pready), .pslverr_in(pslverr));
   sfr_bank u_dut (.clock_in(clock_in), .rst_in(rst_in), .power_on_in(power_on_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .wdt_interval_mode_in(wmode), .wdt_event_in(wev), .osc_fault_in(osc),
      .pin_reset_mode_in(pmode), .pin_event_in(pev), .flash_violation_in(flash),
      .wdt_irq_out(wirq), .shared_irq_out(sirq), .irq_out(irq));

   // Free-running 100 MHz clock
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      u_core.xfer(1'b1, a, d, rd, err);
   endtask : wr

   task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
      u_core.xfer(1'b0, a, 32'h0000_0000, rd, err);
      chk(name, rd, exp);
   endtask : rdc

   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask : tick

   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report

   // Hang guard, far above the expected run
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         final_report();
      end
   end

   initial begin
      rst_in = 1'b1;
      power_on_in = 1'b1;
      {wmode, wev, osc, pmode, pev, flash} = 6'h00;
      tick(4);
      rst_in <= 1'b0;
      power_on_in <= 1'b0;
      rdc("en_rst", 32'h00, 32'h0000_0000);
      rdc("flg_rst", 32'h08, 32'h0000_0006);
      wr(32'h00, 32'hffff_ffff);
      rdc("en_rw", 32'h00, {24'h0, SFR_ENABLE_MASK});
      wr(32'h08, 32'hffff_ffff);
      rdc("flg_rw", 32'h08, {24'h0, SFR_FLAG_MASK});
      wr(32'h04, 32'hffff_ffff);
      wr(32'h0c, 32'hffff_ffff);
      rdc("byte1", 32'h04, 32'h0000_0000);
      rdc("byte3", 32'h0c, 32'h0000_0000);
      chk("map_err", 32'(err), 32'h0);
      u_core.xfer(1'b0, 32'h40, 32'h0000_0000, rd, err);
      chk("unmap_err", 32'(err), 32'h1);
      chk("unmap_rd", rd, 32'h0000_0000);
      wr(32'h08, 32'h0000_0000);
      rdc("flg_clr", 32'h08, 32'h0000_0000);
      chk("sh_idle", 32'(sirq), 32'h0);
      // Watchdog event, gated by mode
      wev <= 1'b1;
      tick(1);
      wev <= 1'b0;
      tick(3);
      chk("wdt_rstmode", 32'(wirq), 32'h0);
      wmode <= 1'b1;
      tick(3);
      chk("wdt_interval", 32'(wirq), 32'h1);
      // Oscillator fault, synchronised level
      osc <= 1'b1;
      tick(6);
      osc <= 1'b0;
      tick(4);
      rdc("flg_osc", 32'h08, 32'h0000_0003);
      chk("sh_osc", 32'(sirq), 32'h1);
      wr(32'h00, 32'h0000_0031);
      tick(2);
      chk("sh_osc_off", 32'(sirq), 32'h0);
      // Shared pin in reset mode, then event mode
      pmode <= 1'b1;
      pev <= 1'b1;
      tick(6);
      pev <= 1'b0;
      tick(4);
      rdc("flg_pinrst", 32'h08, 32'h0000_000b);
      pmode <= 1'b0;
      pev <= 1'b1;
      tick(6);
      pev <= 1'b0;
      tick(4);
      rdc("flg_pinev", 32'h08, 32'h0000_001b);
      chk("sh_pin", 32'(sirq), 32'h1);
      wr(32'h08, 32'h0000_0000);
      wr(32'h00, 32'h0000_0020);
      flash <= 1'b1;
      tick(3);
      chk("sh_flash", 32'(sirq), 32'h1);
      flash <= 1'b0;
      tick(3);
      chk("sh_flash_off", 32'(sirq), 32'h0);
      // Sticky status, mask and clear by writing ones
      rdc("status", 32'h10, 32'h0000_000f);
      chk("irq_masked", 32'(irq), 32'h0);
      wr(32'h14, 32'h0000_0004);
      tick(2);
      chk("irq_on", 32'(irq), 32'h1);
      wr(32'h10, 32'h0000_000f);
      rdc("status_clr", 32'h10, 32'h0000_0000);
      chk("irq_off", 32'(irq), 32'h0);
      // Power-up clear keeps the power-on-only flags
      wr(32'h00, 32'h0000_00ff);
      wr(32'h08, 32'h0000_001f);
      rst_in <= 1'b1;
      tick(1);
      rst_in <= 1'b0;
      rdc("en_puc", 32'h00, 32'h0000_0000);
      rdc("flg_puc", 32'h08, 32'h0000_000f);
      power_on_in <= 1'b1;
      tick(1);
      power_on_in <= 1'b0;
      rdc("flg_por", 32'h08, 32'h0000_0006);
      final_report();
   end
endmodule : tb_special_function_regs
